// file: bench/ccio_counter_asserts.sv
// Port checker for the counter channel block.
// Assumes it is bound into ccio_counter and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ccio_counter_asserts (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Outputs
	input wire logic [3:0]  dout,
	input wire logic [3:0]  cmp_flag,
	input wire logic        proc_irq,
	input wire logic        diag_irq
);
	logic       wr_en;
	logic       cw;
	logic [1:0] om_q;
	logic [3:0] ov_q;
	logic       arm_q;
	assign wr_en = psel && penable && pwrite;
	assign cw = wr_en && paddr == 8'h0C;
	// Shadow of channel 0 mode, plain outputs, enabled events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			om_q <= 2'h0;
			ov_q <= 4'h0;
			arm_q <= 1'b0;
		end else if (wr_en) begin
			if (paddr == 8'h40) om_q <= pwdata[5:4];
			if (paddr == 8'h04) ov_q <= pwdata[7:4];
			if (paddr[7:6] == 2'h1 && paddr[3:0] == 4'h0 && pwdata[15:11] != 5'h0) arm_q <= 1'b1;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_none;
		om_q == 2'h0 [*3];
	endsequence
	sequence s_ge;
		om_q == 2'h1 [*3];
	endsequence
	property p_rdy; pready; endproperty
	property p_err; pslverr |-> psel && penable; endproperty
	property p_diag; diag_irq |-> proc_irq; endproperty
	property p_clr; $fell(proc_irq) |-> $past(cw); endproperty
	property p_arm; !arm_q |-> !proc_irq; endproperty
	property p_none_flag; s_none |-> !cmp_flag[0]; endproperty
	property p_none_out; s_none ##0 $stable(ov_q) |-> dout[0] == ov_q[0]; endproperty
	property p_ge; s_ge |-> dout[0] == cmp_flag[0]; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	a_err: assert property (p_err) else $error("pslverr outside access");
	a_diag: assert property (p_diag) else $error("diag pulse without pending");
	a_clr: assert property (p_clr) else $error("pending cleared without write");
	a_arm: assert property (p_arm) else $error("interrupt while disabled");
	a_none_flag: assert property (p_none_flag) else $error("flag set in plain mode");
	a_none_out: assert property (p_none_out) else $error("plain output wrong");
	a_ge: assert property (p_ge) else $error("output and flag differ");
endmodule // ccio_counter_asserts
bind ccio_counter ccio_counter_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .dout(dout), .cmp_flag(cmp_flag), .proc_irq(proc_irq),
	.diag_irq(diag_irq));
`default_nettype wire

// file: bench/ccio_counter_tb.sv
// Self-checking bench for the counter channel block.
// Assumes short filter and tick parameters; channels 0 and 3 get models.
`timescale 1ns/10ps
`default_nettype none
module ccio_counter_tb
	import ccio_pkg::*;
;
	localparam int TK = 20;
	logic pclk = 1'b0;
	logic presetn;
	logic psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat, c0, r;
	logic pready, pslverr, perr, proc_irq, diag_irq, up;
	logic diag_seen = 1'b0;
	logic [3:0] dout, cmp_flag;
	wire ccio_pins_t [3:0] pins;
	int mismatches = 0;
	int checks_done = 0;
	int i, m, w;
	logic [31:0] s = 32'd8829;
	assign pins[2:1] = '0;
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (diag_irq === 1'b1) diag_seen <= 1'b1;
	ccio_enc_model enc0 (.pclk(pclk), .p(pins[0]));
	ccio_enc_model enc3 (.pclk(pclk), .p(pins[3]));
	ccio_counter #(.FLT_CYC('{4, 4, 4, 4, 4, 4, 4}), .TICK_CYC(TK)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .dout(dout), .cmp_flag(cmp_flag),
		.proc_irq(proc_irq), .diag_irq(diag_irq));
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	function automatic logic [31:0] exp_delta(input logic [2:0] k, input logic u, input int n);
		logic [31:0] d;
		d = (k[1:0] == 2'h0) ? n : n >> (3 - k[1:0]);
		return (u ^ k[2]) ? d : -d;
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			disable scenarios;
		end
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wt();
		repeat (12) @(posedge pclk);
	endtask
	task automatic meas(output int len);
		int n;
		len = 0;
		for (n = 0; n < 80 && dout[0] !== 1'b1; n++) @(posedge pclk);
		while (dout[0] === 1'b1 && len < 300) begin
			@(posedge pclk);
			len++;
		end
	endtask
	////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		begin : scenarios
		apb(0, 8'h40, 0);
		chk(rdat, 32'h500);
		apb(0, 8'h44, 0);
		chk(rdat, 0);
		apb(0, 8'h00, 0);
		chk(rdat, 0);
		apb(0, 8'hF0, 0);
		chk({rdat[30:0], perr}, 1);
		apb(1, 8'h04, 32'hAF);
		wt();
		chk(32'(dout), 32'hA);
		chk(32'(cmp_flag), 0);
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			apb(1, 8'h40, 32'h500 | {28'h0, i[2], 1'b0, i[1:0]});
			r = rnd();
			up = r[0];
			m = (i[1:0] == 0) ? r[2:1] + 1 : 4 * (r[2] + 1);
			apb(0, 8'h48, 0);
			c0 = rdat;
			apb(1, 8'h48, r);
			repeat (m) enc0.move(up, i[1:0] != 0);
			wt();
			apb(0, 8'h48, 0);
			chk(rdat, c0 + exp_delta(i[2:0], up, m));
		end
		$display("test evaluation done");
		apb(1, 8'h00, 1);
		apb(1, 8'h70, 32'h1D04);
		apb(0, 8'h78, 0);
		c0 = rdat;
		enc3.move(1, 0);
		wt();
		apb(0, 8'h78, 0);
		chk(rdat, c0);
		enc3.gate(1);
		wt();
		chk(32'(proc_irq), 1);
		apb(0, 8'h0C, 0);
		chk(rdat, 32'h61);
		apb(1, 8'h0C, 0);
		enc3.move(1, 0);
		wt();
		apb(0, 8'h78, 0);
		chk(rdat, c0 + 1);
		enc3.gate(0);
		wt();
		apb(0, 8'h0C, 0);
		chk(rdat, 32'h62);
		apb(1, 8'h0C, 0);
		apb(1, 8'h70, 32'h1D00);
		enc3.move(1, 0);
		wt();
		apb(0, 8'h78, 0);
		chk(rdat, c0 + 2);
		apb(1, 8'h04, 32'hA7);
		enc3.gate(1);
		wt();
		chk(32'(proc_irq), 0);
		enc3.gate(0);
		apb(1, 8'h04, 32'hAF);
		$display("test gate done");
		apb(1, 8'h00, 2);
		apb(0, 8'h48, 0);
		c0 = rdat;
		apb(1, 8'h44, c0 + 1);
		apb(1, 8'h40, 32'h2510);
		wt();
		chk(32'(dout[0]), 0);
		enc0.move(1, 0);
		wt();
		chk({30'h0, cmp_flag[0], dout[0]}, 3);
		chk(32'(proc_irq), 1);
		apb(0, 8'h0C, 0);
		chk(rdat, 4);
		enc0.move(0, 0);
		wt();
		chk(32'(dout[0]), 0);
		enc0.move(1, 0);
		wt();
		chk(32'(diag_seen), 1);
		apb(1, 8'h0C, 0);
		apb(1, 8'h40, 32'h520);
		wt();
		chk(32'(dout[0]), 1);
		enc0.move(1, 0);
		wt();
		chk(32'(dout[0]), 0);
		enc0.move(0, 0);
		$display("test compare done");
		apb(1, 8'h40, 32'h020530);
		enc0.move(0, 0);
		fork
			meas(w);
			begin
				enc0.move(1, 0);
				apb(1, 8'h40, 32'h010530);
				enc0.move(0, 0);
				enc0.move(1, 0);
			end
		join
		chk(w, 2 * TK);
		enc0.move(0, 0);
		fork
			meas(w);
			enc0.move(1, 0);
		join
		chk(w, TK);
		apb(1, 8'h40, 32'h0105B0);
		enc0.move(0, 0);
		fork
			meas(w);
			enc0.move(1, 0);
		join
		chk(w, 0);
		enc0.move(1, 0);
		fork
			meas(w);
			enc0.move(0, 0);
		join
		chk(w, TK);
		apb(1, 8'h40, 32'h000530);
		wt();
		chk(32'(dout[0]), 1);
		enc0.move(1, 0);
		wt();
		chk(32'(dout[0]), 0);
		$display("test pulse done");
		end
		print_verdict();
	end
endmodule // ccio_counter_tb
`default_nettype wire

// file: bench/ccio_enc_model.sv
// Encoder or pulse source driving one channel's pins.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module ccio_enc_model
	import ccio_pkg::*;
#(
	parameter int HOLD = 5
) (
	// Clock
	input  wire logic pclk,
	// Pins
	output ccio_pins_t p
);
	initial p = '0;
	task automatic hold();
		repeat (HOLD) @(posedge pclk);
	endtask
	// Gray phases put a ahead of b when going up
	task automatic move(input logic up, input logic quad);
		logic [1:0] ph;
		if (quad) begin
			ph = {p.b, p.a ^ p.b};
			ph = up ? ph + 2'h1 : ph - 2'h1;
			p.a <= ph[0] ^ ph[1];
			p.b <= ph[1];
		end else begin
			p.a <= 1'b0;
			p.b <= up;
			hold();
			p.a <= 1'b1;
			hold();
			p.a <= 1'b0;
		end
		hold();
	endtask
	task automatic gate(input logic v);
		p.gate <= v;
		hold();
	endtask
endmodule // ccio_enc_model
`default_nettype wire

// file: design/ccio_counter.sv
// Four-channel counter: input evaluation, compare output and event reporting.
// Assumes an APB master on pclk; encoder and gate pins may be asynchronous.
// Functional notes
// - Pulse/direction mode counts pulse edges, direction level picks up or down.
// - Encoder mode decodes two phases, counting once, twice or four times per cycle.
// - Only channel 3 has hardware gate; enabled, both gates must be open.
// - Hardware gate disabled by default; channel 3 then gated by software alone.
// - Direction invert option flips the direction input; off by default.
// - No-comparison default: output is a plain output, comparator flag stays low.
// - Comparator mode drives output and flag while count >= or <= compare value.
// - Pulse mode asserts output for programmed duration when count reaches compare.
// - With main direction set, pulse fires only when reached in that direction; with duration 0 the code ignores main direction.
// - Pulse timing starts when the output is set.
// - Re-reaching compare value during a pulse neither restarts nor extends it.
// - Changed duration applies from the next pulse, not the current one.
// - Duration zero keeps output set while the compare condition holds.
// - Duration 0 to 510 ms in 2 ms steps, error under 1 ms, default 0.
// - Count frequency limit 1..100 kHz sets minimum accepted pulse width; default 60 kHz.
// - Gate-open event: rising hardware gate edge on channel 3 with software gate open.
// - Gate-close event: falling hardware gate edge on channel 3 with software gate open.
// - Comparator event raises an interrupt each time the comparator fires.
// - Overflow event raises an interrupt when count passes its upper limit.
// - Underflow event raises an interrupt when count passes its lower limit.
// - All interrupt sources disabled after reset.
// - Diagnostics-plus-process mode raises diagnostic interrupt only on a lost interrupt.
// - Each channel shows its signed 32-bit count as a readable word.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "ccio_regs.svh"
`default_nettype none

module ccio_counter
	import ccio_pkg::*;
#(
	parameter int unsigned FLT_CYC [7] = '{
		`CCIO_CYC_UP(`CCIO_FLT0_NS), `CCIO_CYC_UP(`CCIO_FLT1_NS),
		`CCIO_CYC_UP(`CCIO_FLT2_NS), `CCIO_CYC_UP(`CCIO_FLT3_NS),
		`CCIO_CYC_UP(`CCIO_FLT4_NS), `CCIO_CYC_UP(`CCIO_FLT5_NS),
		`CCIO_CYC_UP(`CCIO_FLT6_NS)},
	parameter int unsigned TICK_CYC = `CCIO_TICK_CYC
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// APB slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// Channel pins
	input  wire ccio_pins_t [3:0] pins,
	output logic      [3:0]       dout,
	output logic      [3:0]       cmp_flag,
	// Interrupt requests
	output logic                  proc_irq,
	output logic                  diag_irq
);

	////////////////////////////////////////////////////////////////////////////////
	ccio_state_t s_q;
	ccio_state_t s_d;

	logic        setup;
	logic        access;
	logic        hit;
	logic [31:0] rd;
	logic        cause_clr;

	assign setup     = psel & ~penable;
	assign access    = psel & penable;
	assign cause_clr = access & pwrite & (paddr == `CCIO_CAUSE_OFS);

	// Read decode; hit is low for unmapped offsets
	always_comb begin
		rd  = 32'h00000000;
		hit = 1'b1;
		if (paddr[7:6] == `CCIO_CH_BASE) begin
			case (paddr[3:0])
				`CCIO_CH_CFG: begin
					rd = {8'h00, s_q.cfg[paddr[5:4]]};
				end
				`CCIO_CH_CMP: begin
					rd = s_q.cmp[paddr[5:4]];
				end
				`CCIO_CH_CNT: begin
					rd = s_q.ch[paddr[5:4]].cnt;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end else begin
			case (paddr)
				`CCIO_GCFG_OFS: begin
					rd = {30'h00000000, s_q.imode};
				end
				`CCIO_GATE_OFS: begin
					rd = {24'h000000, s_q.swout, s_q.swgate};
				end
				`CCIO_STAT_OFS: begin
					rd = {23'h000000, s_q.pend, s_q.ch[3].dout, s_q.ch[2].dout,
						s_q.ch[1].dout, s_q.ch[0].dout, s_q.ch[3].flag,
						s_q.ch[2].flag, s_q.ch[1].flag, s_q.ch[0].flag};
				end
				`CCIO_CAUSE_OFS: begin
					rd = {25'h0000000, s_q.cause};
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [2:0]  fo;
		logic [2:0]  fn;
		logic [17:0] lim;
		logic [2:0]  fsel;
		logic        a_r;
		logic        a_f;
		logic        b_e;
		logic        step;
		logic        up;
		logic        open;
		logic [31:0] nc;
		logic        ovf;
		logic        unf;
		logic        eq;
		logic        cond;
		logic        reach;
		logic        fire;
		logic [4:0]  evs;
		logic        pendb;
		logic        taken;
		logic        lost;
		fo    = 3'b000;
		fn    = 3'b000;
		lim   = 18'h00000;
		fsel  = 3'd0;
		a_r   = 1'b0;
		a_f   = 1'b0;
		b_e   = 1'b0;
		step  = 1'b0;
		up    = 1'b0;
		open  = 1'b0;
		nc    = 32'h00000000;
		ovf   = 1'b0;
		unf   = 1'b0;
		eq    = 1'b0;
		cond  = 1'b0;
		reach = 1'b0;
		fire  = 1'b0;
		evs   = 5'h00;
		taken = 1'b0;
		lost  = 1'b0;
		s_d      = s_q;
		s_d.diag = 1'b0;
		pendb    = s_q.pend & ~cause_clr;

		for (int c = 0; c < 4; c++) begin
			// Two-stage synchroniser, then width filter
			s_d.ch[c].s1 = pins[c];
			s_d.ch[c].s2 = s_q.ch[c].s1;
			fsel = (s_q.cfg[c].fsel > `CCIO_FSEL_MAX) ? `CCIO_FSEL_MAX : s_q.cfg[c].fsel;
			lim  = 18'(FLT_CYC[fsel] - 1);
			for (int k = 0; k < 3; k++) begin
				if (s_q.ch[c].s2[k] != s_q.ch[c].filt[k]) begin
					if (s_q.ch[c].fcnt[k] >= lim) begin
						s_d.ch[c].filt[k] = s_q.ch[c].s2[k];
						s_d.ch[c].fcnt[k] = 18'h00000;
					end else begin
						s_d.ch[c].fcnt[k] = s_q.ch[c].fcnt[k] + 18'h00001;
					end
				end else begin
					s_d.ch[c].fcnt[k] = 18'h00000;
				end
			end
			fo  = s_q.ch[c].filt;
			fn  = s_d.ch[c].filt;
			a_r = fn[2] & ~fo[2];
			a_f = fo[2] & ~fn[2];
			b_e = fn[1] ^ fo[1];

			// Edge evaluation
			case (s_q.cfg[c].eval)
				CCIO_EV_PDIR: begin
					step = a_r;
					up   = fn[1];
				end
				CCIO_EV_SINGLE: begin
					step = a_r;
					up   = ~fn[1];
				end
				CCIO_EV_DOUBLE: begin
					step = a_r | a_f;
					up   = fn[2] ^ fn[1];
				end
				CCIO_EV_QUAD: begin
					step = a_r | a_f | b_e;
					up   = (a_r | a_f) ? (fn[2] ^ fn[1]) : ~(fn[2] ^ fn[1]);
				end
				default: begin
					step = 1'b0;
					up   = 1'b0;
				end
			endcase
			up = up ^ s_q.cfg[c].dinv;

			// Gate: hardware gate exists on channel 3 only
			open = s_q.swgate[c];
			if (c == 3 && s_q.cfg[c].hwen) begin
				open = s_q.swgate[c] & fn[0];
			end
			step = step & open;

			// Counter with signed wrap at the limits
			nc  = s_q.ch[c].cnt;
			ovf = 1'b0;
			unf = 1'b0;
			if (step) begin
				nc  = up ? s_q.ch[c].cnt + 32'h00000001 : s_q.ch[c].cnt - 32'h00000001;
				ovf = up & (s_q.ch[c].cnt == `CCIO_CNT_MAX);
				unf = ~up & (s_q.ch[c].cnt == `CCIO_CNT_MIN);
			end
			s_d.ch[c].cnt = nc;

			// Compare output
			eq    = (nc == s_q.cmp[c]);
			reach = step & eq & (s_q.ch[c].cnt != s_q.cmp[c]) &
				((s_q.cfg[c].mdir == CCIO_MD_NONE) |
				((s_q.cfg[c].mdir == CCIO_MD_UP) & up) |
				((s_q.cfg[c].mdir == CCIO_MD_DOWN) & ~up));
			fire = 1'b0;
			case (s_q.cfg[c].omode)
				CCIO_OM_NONE: begin
					s_d.ch[c].cond_q = 1'b0;
					s_d.ch[c].pact   = 1'b0;
					s_d.ch[c].dout   = s_q.swout[c];
					s_d.ch[c].flag   = 1'b0;
				end
				CCIO_OM_GE, CCIO_OM_LE: begin
					cond = (s_q.cfg[c].omode == CCIO_OM_GE) ?
						($signed(nc) >= $signed(s_q.cmp[c])) :
						($signed(nc) <= $signed(s_q.cmp[c]));
					fire             = cond & ~s_q.ch[c].cond_q;
					s_d.ch[c].cond_q = cond;
					s_d.ch[c].pact   = 1'b0;
					s_d.ch[c].dout   = cond;
					s_d.ch[c].flag   = cond;
				end
				CCIO_OM_PULSE: begin
					s_d.ch[c].cond_q = eq;
					if (s_q.ch[c].pact) begin
						// Running pulse ignores new reaches
						if (s_q.ch[c].pcyc >= 18'(TICK_CYC - 1)) begin
							s_d.ch[c].pcyc = 18'h00000;
							if (s_q.ch[c].prem <= 8'h01) begin
								s_d.ch[c].pact = 1'b0;
							end else begin
								s_d.ch[c].prem = s_q.ch[c].prem - 8'h01;
							end
						end else begin
							s_d.ch[c].pcyc = s_q.ch[c].pcyc + 18'h00001;
						end
						s_d.ch[c].dout = s_d.ch[c].pact;
					end else if (s_q.cfg[c].pdur == 8'h00) begin
						s_d.ch[c].dout = eq;
						fire           = eq & ~s_q.ch[c].cond_q;
					end else if (reach) begin
						s_d.ch[c].pact = 1'b1;
						s_d.ch[c].prem = s_q.cfg[c].pdur;
						s_d.ch[c].pcyc = 18'h00000;
						s_d.ch[c].dout = 1'b1;
						fire           = 1'b1;
					end else begin
						s_d.ch[c].dout = 1'b0;
					end
					s_d.ch[c].flag = s_d.ch[c].dout;
				end
				default: begin
					s_d.ch[c].dout = 1'b0;
					s_d.ch[c].flag = 1'b0;
				end
			endcase

			// Events, each gated by its enable
			evs = {unf, ovf, fire, 2'b00};
			if (c == 3) begin
				evs[0] = ~fo[0] & fn[0] & s_q.swgate[c];
				evs[1] = fo[0] & ~fn[0] & s_q.swgate[c];
			end
			evs = evs & s_q.cfg[c].ev_en;
			if ((|evs) && (s_q.imode != CCIO_IM_NONE)) begin
				if (!taken && !pendb) begin
					taken     = 1'b1;
					s_d.cause = {2'(c), evs};
				end else begin
					lost = 1'b1;
				end
			end
		end

		// New event wins over a clear in the same cycle
		s_d.pend = pendb | taken;
		s_d.diag = lost & (s_q.imode == CCIO_IM_DIAG);

		// Register writes in the access phase
		if (access && pwrite) begin
			if (paddr[7:6] == `CCIO_CH_BASE) begin
				if (paddr[3:0] == `CCIO_CH_CFG) begin
					s_d.cfg[paddr[5:4]] = ccio_cfg_t'(pwdata[`CCIO_CFG_W-1:0]);
				end else if (paddr[3:0] == `CCIO_CH_CMP) begin
					s_d.cmp[paddr[5:4]] = pwdata;
				end
			end else if (paddr == `CCIO_GCFG_OFS) begin
				s_d.imode = ccio_imode_t'(pwdata[1:0]);
			end else if (paddr == `CCIO_GATE_OFS) begin
				s_d.swgate = pwdata[`CCIO_GATE_SW_LO +: 4];
				s_d.swout  = pwdata[`CCIO_GATE_OUT_LO +: 4];
			end
		end

		// Read data and error captured in the setup phase
		if (setup) begin
			s_d.prdata = pwrite ? 32'h00000000 : rd;
			s_d.perr   = ~hit;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			for (int c = 0; c < 4; c++) begin
				s_q.cfg[c] <= ccio_cfg_t'(`CCIO_CFG_RST);
				s_q.cmp[c] <= `CCIO_CMP_RST;
			end
			s_q.imode <= ccio_imode_t'(`CCIO_GCFG_RST);
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign prdata   = s_q.prdata;
	assign pready   = 1'b1;
	assign pslverr  = access & s_q.perr;
	assign proc_irq = s_q.pend;
	assign diag_irq = s_q.diag;

	always_comb begin
		for (int c = 0; c < 4; c++) begin
			dout[c]     = s_q.ch[c].dout;
			cmp_flag[c] = s_q.ch[c].flag;
		end
	end

endmodule // ccio_counter

`default_nettype wire

// file: include/ccio_pkg.sv
// Types of the counter channel block.
// Assumes ccio_regs.svh supplies the numeric constants.
`default_nettype none
package ccio_pkg;

	typedef enum logic [1:0] {
		CCIO_EV_PDIR   = 2'b00,
		CCIO_EV_SINGLE = 2'b01,
		CCIO_EV_DOUBLE = 2'b10,
		CCIO_EV_QUAD   = 2'b11
	} ccio_eval_t;

	typedef enum logic [1:0] {
		CCIO_OM_NONE  = 2'b00,
		CCIO_OM_GE    = 2'b01,
		CCIO_OM_LE    = 2'b10,
		CCIO_OM_PULSE = 2'b11
	} ccio_omode_t;

	typedef enum logic [1:0] {
		CCIO_MD_NONE = 2'b00,
		CCIO_MD_UP   = 2'b01,
		CCIO_MD_DOWN = 2'b10,
		CCIO_MD_RSV  = 2'b11
	} ccio_mdir_t;

	typedef enum logic [1:0] {
		CCIO_IM_NONE = 2'b00,
		CCIO_IM_PROC = 2'b01,
		CCIO_IM_DIAG = 2'b10,
		CCIO_IM_RSV  = 2'b11
	} ccio_imode_t;

	// Event bits: 0 gate open, 1 gate close, 2 compare, 3 overflow, 4 underflow
	typedef struct packed {
		logic [7:0]  pdur;
		logic [4:0]  ev_en;
		logic [2:0]  fsel;
		ccio_mdir_t  mdir;
		ccio_omode_t omode;
		logic        dinv;
		logic        hwen;
		ccio_eval_t  eval;
	} ccio_cfg_t;

	typedef struct packed {
		logic a;
		logic b;
		logic gate;
	} ccio_pins_t;

	typedef struct packed {
		logic [2:0]       s1;
		logic [2:0]       s2;
		logic [2:0]       filt;
		logic [2:0][17:0] fcnt;
		logic [31:0]      cnt;
		logic             cond_q;
		logic             pact;
		logic [17:0]      pcyc;
		logic [7:0]       prem;
		logic             dout;
		logic             flag;
	} ccio_ch_t;

	typedef struct packed {
		ccio_ch_t  [3:0]       ch;
		ccio_cfg_t [3:0]       cfg;
		logic      [3:0][31:0] cmp;
		ccio_imode_t           imode;
		logic      [3:0]       swgate;
		logic      [3:0]       swout;
		logic                  pend;
		logic      [6:0]       cause;
		logic                  diag;
		logic      [31:0]      prdata;
		logic                  perr;
	} ccio_state_t;

endpackage
`default_nettype wire

// file: include/ccio_regs.svh
// Register offsets, reset values and timing figures of the counter channel block.
// Assumes a 100 MHz register clock and 32-bit APB data.
`ifndef CCIO_REGS_SVH
`define CCIO_REGS_SVH

// Byte offsets
`define CCIO_GCFG_OFS    8'h00
`define CCIO_GATE_OFS    8'h04
`define CCIO_STAT_OFS    8'h08
`define CCIO_CAUSE_OFS   8'h0C
`define CCIO_CH_BASE     2'h1
`define CCIO_CH_CFG      4'h0
`define CCIO_CH_CMP      4'h4
`define CCIO_CH_CNT      4'h8

// Reset values
`define CCIO_CFG_RST     24'h000500
`define CCIO_CMP_RST     32'h00000000
`define CCIO_GCFG_RST    2'h0

// Field positions
`define CCIO_GATE_SW_LO  0
`define CCIO_GATE_OUT_LO 4
`define CCIO_STAT_OUT_LO 4
`define CCIO_STAT_PEND   8
`define CCIO_CFG_W       24

// Timing
`define CCIO_CLK_NS      10
`define CCIO_STEP_MS     2
`define CCIO_TICK_CYC    ((`CCIO_STEP_MS * 1000000) / `CCIO_CLK_NS)
`define CCIO_CYC_UP(t)   (((t) + `CCIO_CLK_NS - 1) / `CCIO_CLK_NS)
`define CCIO_FLT0_NS     400000
`define CCIO_FLT1_NS     200000
`define CCIO_FLT2_NS     80000
`define CCIO_FLT3_NS     40000
`define CCIO_FLT4_NS     13000
`define CCIO_FLT5_NS     6700
`define CCIO_FLT6_NS     4000
`define CCIO_FSEL_MAX    3'd6

// Signed counting limits
`define CCIO_CNT_MAX     32'h7FFFFFFF
`define CCIO_CNT_MIN     32'h80000000

`endif
